/* File: bench/id_link_slave_properties.sv */
// Port checks for the identification slave
`timescale 1ns/1ps
`default_nettype none
module id_link_slave_properties #(
  // Presence length set on the bench's instance of the slave
  parameter PDL_CYC = 60
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Line and status
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_strobe,
  input wire logic active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Length of the current pull, so the longest can be bounded
  logic [15:0] low_cnt = 16'h0000;
  always @(posedge mclk)
    low_cnt <= dq_oe_n ? 16'h0000 : low_cnt + 16'h0001;
  a_drive_low_only: assert property (dq_out == 1'b0)
    else $error("slave drove high");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> dq_oe_n && !cmd_strobe && !active) else $error("reset");
  a_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("strobe too long");
  a_strobe_active: assert property (cmd_strobe |-> active)
    else $error("strobe while passive");
  a_cmd_hold: assert property ($changed(cmd_byte) |-> cmd_strobe)
    else $error("command changed alone");
  a_passive_quiet: assert property (!active |-> dq_oe_n)
    else $error("passive slave pulls");
  a_zero_hold: assert property ($fell(dq_oe_n) |-> !dq_oe_n[*8])
    else $error("pull too short");
  a_low_bound: assert property (low_cnt <= PDL_CYC + 1)
    else $error("pull too long");
  a_rise_quiet: assert property ($rose(dq_in) |=> dq_oe_n[*8])
    else $error("pull right after rise");
  c_search: cover property (cmd_strobe && cmd_byte == 8'hF0);
  c_pull: cover property ($fell(dq_oe_n));
  c_passive: cover property ($fell(active));
endmodule // id_link_slave_properties
`default_nettype wire

/* File: bench/id_link_slave_tb.sv */
// Self-checking bench for the identification slave
`timescale 1ns/1ps
`default_nettype none
module id_link_slave_tb;
  // Family and serial values are arbitrary
  localparam [63:0] ROM = {8'hA5, 48'h8000_1234_5678, 8'h3C};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire dq, dq_out, dq_oe_n, cmd_strobe, active;
  wire [7:0] cmd_byte;
  logic [31:0] seed = 32'h0000EF4A;
  logic [7:0] exp_cmd[$];
  logic exp_bit[$];
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  id_link_slave #(.FAMILY(ROM[7:0]), .SERIAL(ROM[55:8]), .CRC(ROM[63:56]),
    .RESET_CYC(200), .PDH_CYC(20), .PDL_CYC(60), .SAMPLE_CYC(30),
    .HOLD0_CYC(30)) i_dut (.mclk(mclk), .rst(rst), .dq_in(dq),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .cmd_byte(cmd_byte),
    .cmd_strobe(cmd_strobe), .active(active));
  line_master_model i_master (.mclk(mclk), .dq_oe_n(dq_oe_n), .dq(dq));
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [7:0] e, s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("wrong value %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (cmd_strobe === 1'b1)
      check("command", exp_cmd.pop_front(), cmd_byte);
    if (i_master.rd_done === 1'b1)
      check("bit", exp_bit.pop_front(), i_master.rd_bit);
  end
  // Random recovery time moves every later fall of the line
  task automatic go(input logic wr, input logic rd);
    i_master.slot(wr, rd);
    i_master.hold(nxt() % 16);
  endtask
  task automatic rd_bits(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      exp_bit.push_back(v[i]);
      go(1'b1, 1'b1);
    end
  endtask
  task automatic send_cmd(input logic [7:0] c);
    exp_bit.push_back(1'b0);
    i_master.line_reset();
    exp_cmd.push_back(c);
    for (int i = 0; i < 8; i++)
      go(c[i], 1'b0);
  endtask
  task automatic quiet(input int n);
    rd_bits({64{1'b1}}, n);
    check("active", 8'h00, {7'h00, active});
    check("drive level", 8'h00, {7'h00, dq_out});
  endtask
  initial begin
    int k;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      send_cmd(j ? 8'h0F : 8'h33);
      rd_bits(ROM, 64);
      quiet(2);
    end
    for (int j = 0; j < 3; j++) begin
      send_cmd(j == 0 ? 8'h55 : (j == 1 ? 8'hCC : 8'hA5));
      quiet(8);
    end
    // First pass follows every bit, second loses at a random bit
    for (int j = 0; j < 2; j++) begin
      k = j ? nxt() % 64 : 64;
      send_cmd(8'hF0);
      for (int i = 0; i < 64 && i <= k; i++) begin
        rd_bits({63'h0, ROM[i]}, 1);
        rd_bits({63'h0, ~ROM[i]}, 1);
        go(ROM[i] ^ (i == k), 1'b0);
      end
      quiet(2);
    end
    // Every note must have met its result
    check("notes left", 8'h00,
      8'(exp_cmd.size() + exp_bit.size()));
    give_verdict();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
endmodule // id_link_slave_tb
bind id_link_slave id_link_slave_properties i_props (
  .mclk(mclk), .rst(rst), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe_n(dq_oe_n), .cmd_byte(cmd_byte), .cmd_strobe(cmd_strobe),
  .active(active));
`default_nettype wire

/* File: bench/line_master_model.sv */
// Bus master model with pull-up for the single-wire line
`timescale 1ns/1ps
`default_nettype none
module line_master_model (
  // Clock
  input wire logic mclk,
  // Line
  input wire logic dq_oe_n,
  output wire logic dq
);
  logic pull = 1'b0;
  logic rd_done = 1'b0;
  logic rd_bit = 1'b0;
  // Wired-AND with the pull-up supplying the high level
  assign dq = ~pull & dq_oe_n;
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic line_reset();
    pull <= 1'b1;
    hold(250);
    pull <= 1'b0;
    hold(40);
    rd_bit <= dq;
    rd_done <= 1'b1;
    hold(1);
    rd_done <= 1'b0;
    hold(60);
  endtask
  // Read slots are short-low write-one slots sampled 15 cycles after the fall
  task automatic slot(input logic wr, input logic rd);
    pull <= 1'b1;
    hold(wr ? 5 : 60);
    pull <= 1'b0;
    hold(10);
    rd_bit <= dq;
    rd_done <= rd;
    hold(1);
    rd_done <= 1'b0;
    hold(wr ? 64 : 9);
  endtask
endmodule // line_master_model
`default_nettype wire

/* File: rtl/cmd_fifo.v */
// Small valid/ready FIFO carrying received command bytes
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Write side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Read side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // cmd_fifo
`default_nettype wire

/* File: rtl/id_link_regs.vh */
// Constants for the single-wire identification slave
`ifndef ID_LINK_REGS_VH
`define ID_LINK_REGS_VH
// ----------------------------------------
// Timing, in microseconds and clock cycles
// ----------------------------------------
`define CLK_MHZ 100
`define T_RESET_US 120
`define T_RESET_CYC (`T_RESET_US * `CLK_MHZ)
`define T_PDH_US 30
`define T_PDH_CYC (`T_PDH_US * `CLK_MHZ)
`define T_PDL_US 120
`define T_PDL_CYC (`T_PDL_US * `CLK_MHZ)
`define T_SAMPLE_US 30
`define T_SAMPLE_CYC (`T_SAMPLE_US * `CLK_MHZ)
`define T_HOLD0_US 30
`define T_HOLD0_CYC (`T_HOLD0_US * `CLK_MHZ)
// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_READ_A 8'h33
`define CMD_READ_B 8'h0F
`define CMD_MATCH 8'h55
`define CMD_SKIP 8'hCC
`define CMD_SEARCH 8'hF0
// ----------------------------------------
// ROM layout and defaults
// ----------------------------------------
`define ROM_FAMILY_LSB 0
`define ROM_SERIAL_LSB 8
`define ROM_CRC_LSB 56
`define FAMILY_DEFAULT 8'h5A
`define SERIAL_DEFAULT 48'h0000_0000_0001
`define CRC_DEFAULT 8'h00
`define FIFO_DEPTH 4
`define FIFO_WIDTH 8
`endif

/* File: rtl/id_link_slave.v */
// Slave end of a single-wire open-drain identification link
//
// Function
// - All command and ROM bits travel least significant bit first.
// - Each bit slot starts at the master's falling edge; slave times from it.
// - Line idles high; low longer than 120 us is taken as reset.
// - Every transaction begins with master reset then slave presence pulse.
// - Commands are eight bits, decoded once all eight have arrived.
// - Either read code makes the slave send its whole 64-bit ROM.
// - ROM is family code, serial number, then CRC, family at LSB end.
// - Read only with one slave; several senders give a wired-AND.
// - Match or skip codes silence the slave until the next reset.
// - Search sends each bit, its complement, then reads master's choice.
// - Slave only pulls low or releases; pull-up supplies the high.
// - After reset rises, wait then pull low as presence pulse.
// - In a write slot, sample the line a fixed delay after the fall.
// - In a read slot, hold low a fixed delay to send zero.
`timescale 1ns/1ps
`default_nettype none
`include "id_link_regs.vh"
module id_link_slave #(
  parameter [7:0] FAMILY = `FAMILY_DEFAULT, // Arbitrary value
  parameter [47:0] SERIAL = `SERIAL_DEFAULT, // Arbitrary value
  parameter [7:0] CRC = `CRC_DEFAULT,
  parameter RESET_CYC = `T_RESET_CYC,
  parameter PDH_CYC = `T_PDH_CYC,
  parameter PDL_CYC = `T_PDL_CYC,
  parameter SAMPLE_CYC = `T_SAMPLE_CYC,
  parameter HOLD0_CYC = `T_HOLD0_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Data line, open drain
  input wire dq_in,
  output reg dq_out,
  output reg dq_oe_n,
  // Status
  output reg [7:0] cmd_byte,
  output reg cmd_strobe,
  output reg active
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WAIT = 7'h02;
  localparam [6:0] S_PRES = 7'h04;
  localparam [6:0] S_CMD = 7'h08;
  localparam [6:0] S_READ = 7'h10;
  localparam [6:0] S_SRCH = 7'h20;
  localparam [6:0] S_MUTE = 7'h40;

  wire [63:0] rom;
  reg [6:0] state;
  reg [15:0] low_cnt;
  reg [15:0] tmr;
  reg line_q;
  reg [7:0] shift;
  reg [5:0] bit_idx;
  reg [2:0] cnt3;
  reg [1:0] phase;
  reg in_slot;
  reg pulling;
  wire fall;
  wire rise;
  wire fifo_ready;
  wire fifo_valid;
  wire [7:0] fifo_data;
  reg push;
  reg [7:0] push_data;
  wire cur_bit;
  wire send_bit;

  assign rom = {CRC, SERIAL, FAMILY};
  assign fall = line_q && !dq_in;
  assign rise = !line_q && dq_in;
  assign cur_bit = rom[bit_idx];
  assign send_bit = (state == S_SRCH && phase == 2'd1) ? !cur_bit : cur_bit;

  // ----------------------------------------
  // Command bytes pass through a FIFO
  // ----------------------------------------
  // Decode drains one byte a cycle, so a full FIFO never stalls slots
  cmd_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // Line state machine
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      low_cnt <= 16'h0000;
      tmr <= 16'h0000;
      line_q <= 1'b1;
      shift <= 8'h00;
      bit_idx <= 6'h00;
      cnt3 <= 3'h0;
      phase <= 2'h0;
      in_slot <= 1'b0;
      pulling <= 1'b0;
      push <= 1'b0;
      push_data <= 8'h00;
      dq_out <= 1'b0;
      dq_oe_n <= 1'b1;
      cmd_byte <= 8'h00;
      cmd_strobe <= 1'b0;
      active <= 1'b0;
    end else begin
      line_q <= dq_in;
      push <= 1'b0;
      cmd_strobe <= 1'b0;
      dq_out <= 1'b0;
      dq_oe_n <= !pulling;
      if (!dq_in && !pulling)
        low_cnt <= (low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 1'b1;
      else
        low_cnt <= 16'h0000;
      if (fifo_valid) begin
        cmd_byte <= fifo_data;
        cmd_strobe <= 1'b1;
        case (fifo_data)
          `CMD_READ_A, `CMD_READ_B: state <= S_READ;
          `CMD_SEARCH: state <= S_SRCH;
          `CMD_MATCH, `CMD_SKIP: state <= S_MUTE;
          default: state <= S_MUTE;
        endcase
        bit_idx <= 6'h00;
        phase <= 2'h0;
      end
      if (low_cnt >= RESET_CYC[15:0]) begin
        state <= S_WAIT;
        // Stale slot time would cut the presence delay short
        tmr <= 16'h0000;
        in_slot <= 1'b0;
        pulling <= 1'b0;
        active <= 1'b1;
      end else begin
        case (state)
          S_IDLE: active <= 1'b0;
          S_WAIT: begin
            if (rise) tmr <= 16'h0000;
            else if (dq_in) tmr <= tmr + 1'b1;
            if (dq_in && tmr >= PDH_CYC[15:0]) begin
              state <= S_PRES;
              tmr <= 16'h0000;
              pulling <= 1'b1;
            end
          end
          S_PRES: begin
            tmr <= tmr + 1'b1;
            if (tmr >= PDL_CYC[15:0]) begin
              pulling <= 1'b0;
              state <= S_CMD;
              cnt3 <= 3'h0;
              in_slot <= 1'b0;
            end
          end
          S_CMD: begin
            if (fall && !in_slot) begin
              in_slot <= 1'b1;
              tmr <= 16'h0000;
            end else if (in_slot) begin
              tmr <= tmr + 1'b1;
              if (tmr == SAMPLE_CYC[15:0]) begin
                in_slot <= 1'b0;
                shift <= {dq_in, shift[7:1]};
                cnt3 <= cnt3 + 1'b1;
                if (cnt3 == 3'h7 && fifo_ready) begin
                  push <= 1'b1;
                  push_data <= {dq_in, shift[7:1]};
                end
              end
            end
          end
          S_READ, S_SRCH: begin
            if (fall && !in_slot) begin
              in_slot <= 1'b1;
              tmr <= 16'h0000;
              // Read slot zero: pull low at once, held for a fixed time
              pulling <= (phase != 2'd2) && !send_bit;
            end else if (in_slot) begin
              tmr <= tmr + 1'b1;
              if (phase == 2'd2 && tmr == SAMPLE_CYC[15:0]) begin
                in_slot <= 1'b0;
                phase <= 2'd0;
                bit_idx <= bit_idx + 1'b1;
                if (dq_in != cur_bit) state <= S_MUTE;
                else if (bit_idx == 6'h3F) state <= S_MUTE;
              end else if (phase != 2'd2 && tmr == HOLD0_CYC[15:0]) begin
                pulling <= 1'b0;
                in_slot <= 1'b0;
                if (state == S_SRCH) begin
                  phase <= phase + 1'b1;
                end else begin
                  bit_idx <= bit_idx + 1'b1;
                  if (bit_idx == 6'h3F) state <= S_MUTE;
                end
              end
            end
          end
          S_MUTE: begin
            pulling <= 1'b0;
            active <= 1'b0;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule // id_link_slave
`default_nettype wire
